/* File: rtl/adcs_defs.svh */
/*
 Constants of the converter sequencer: register offsets, field positions, reset values, cycle counts.
 Assumes inclusion by the sequencer file; definitions only.
*/
// Operation
// - After 160 idle system clocks the converter powers its analog part down.
// - Leaving powerdown takes 40 system clocks of power-up.
// - A conversion request from the control register wakes the converter.
// - Single-shot mode does one conversion on the selected channel and then shuts down.
// - The reference level is a pair: high bit in control/status 1, low bit in control 0.
// - A four-bit channel field picks the analog source through the input multiplexer.
// - Writing the continuous select bit as zero selects single-shot conversion.
// - Setting the reference-to-pin bit drives the internal reference out, only with the reference enabled; ref_to_pin here follows the bit ungated.
// - Writing the go bit as one starts a conversion, taking the other control 0 fields in the same write.
// - The go bit reads one for the whole conversion.
// - A single-shot conversion takes 5129 system clocks.
// - A request while powered down adds 40 power-up clocks before the 5129-clock conversion.
// - Completion raises an interrupt request.
// - The result is an 11-bit number.
// - The input multiplexer selects among eight single-ended analog pins shared with GPIO.
`ifndef ADCS_DEFS_SVH
`define ADCS_DEFS_SVH

`define ADCS_OFF_CTL0 12'h000
`define ADCS_OFF_CTL1 12'h004
`define ADCS_OFF_DATA 12'h008
`define ADCS_OFF_IRQ_STAT 12'h00c
`define ADCS_OFF_IRQ_MASK 12'h010

`define ADCS_CTL0_CHAN_LSB 0
`define ADCS_CTL0_CONTINUOUS_SELECT_BIT 4
`define ADCS_CTL0_REFPIN_BIT 5
`define ADCS_CTL0_REFLO_BIT 6
`define ADCS_CTL0_GO_BIT 7
`define ADCS_CTL1_REFHI_BIT 0
`define ADCS_CTL1_BUSY_BIT 1
`define ADCS_CTL1_PDN_BIT 2
`define ADCS_CTL1_WARM_BIT 3
`define ADCS_STAT_DONE_BIT 0

`define ADCS_RST_CTL0 8'h00
`define ADCS_RST_CTL1 1'b0
`define ADCS_RST_MASK 1'b0

`define ADCS_CLK_MHZ 250
`define ADCS_IDLE_CYC 160
`define ADCS_PWRUP_CYC 40
`define ADCS_CONV_CYC 5129
`define ADCS_CNT_W 13

`endif

/* File: rtl/adcs_pkg.sv */
/*
 Types of the converter sequencer: sequencer states and the control 0 field group.
 Assumes nothing beyond the defs header.
*/
package adcs_pkg;
    typedef enum logic [1:0] {
        ST_OFF,
        ST_IDLE,
        ST_WARM,
        ST_CONV
    } adcs_state_t;

    typedef struct packed {
        logic go;
        logic ref_lo;
        logic ref_to_pin;
        logic continuous_select;
        logic [3:0] chan;
    } adcs_ctl0_t;
endpackage

/* File: rtl/adcs_seq.sv */
/*
 Converter sequencer with an AHB-Lite register slave, power sequencing, mux control and completion interrupt.
 Assumes a single AHB-Lite master and a sigma-delta modulator fed by the mux that runs
 on hclk and returns its result on mod_result, so no synchroniser is needed on it.
*/
// Implementation choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "adcs_defs.svh"

module adcs_seq (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [10:0] mod_result,
    output logic [7:0] mux_sel_onehot,
    output logic analog_pdn,
    output logic ref_level_hi_bit,
    output logic ref_level_lo_bit,
    output logic ref_to_pin,
    output logic conv_active,
    output logic irq
);
    // Registers
    adcs_pkg::adcs_ctl0_t ctl0_ff;
    logic ref_hi_ff;
    logic [10:0] result_ff;
    logic done_stat_ff;
    logic done_mask_ff;
    logic irq_ff;
    logic [31:0] hrdata_ff;
    logic [7:0] mux_ff;
    logic pdn_ff;
    logic active_ff;
    adcs_pkg::adcs_state_t state_ff;
    adcs_pkg::adcs_state_t nxt_state;
    logic [`ADCS_CNT_W-1:0] cnt_ff;
    logic [`ADCS_CNT_W-1:0] nxt_cnt;
    logic wr_pend_ff;
    logic [11:0] wr_addr_ff;

    // Bus decode
    wire logic addr_phase = hsel & hready & htrans[1];
    wire logic rd_req = addr_phase & ~hwrite;
    wire logic wr_ctl0 = wr_pend_ff & (wr_addr_ff == `ADCS_OFF_CTL0);
    wire logic wr_ctl1 = wr_pend_ff & (wr_addr_ff == `ADCS_OFF_CTL1);
    wire logic wr_stat = wr_pend_ff & (wr_addr_ff == `ADCS_OFF_IRQ_STAT);
    wire logic wr_mask = wr_pend_ff & (wr_addr_ff == `ADCS_OFF_IRQ_MASK);
    wire logic start_req = wr_ctl0 & hwdata[`ADCS_CTL0_GO_BIT] & ~ctl0_ff.go;
    wire logic [`ADCS_CNT_W-1:0] idle_last = `ADCS_CNT_W'(`ADCS_IDLE_CYC - 1);
    wire logic [`ADCS_CNT_W-1:0] warm_last = `ADCS_CNT_W'(`ADCS_PWRUP_CYC - 1);
    wire logic [`ADCS_CNT_W-1:0] conv_last = `ADCS_CNT_W'(`ADCS_CONV_CYC - 1);
    wire logic conv_done = (state_ff == adcs_pkg::ST_CONV) & (cnt_ff == conv_last);
    // Channel as it stands after this edge, so the mux moves with the write
    wire logic [3:0] nxt_chan = (wr_ctl0 & ~ctl0_ff.go) ? hwdata[`ADCS_CTL0_CHAN_LSB +: 4] : ctl0_ff.chan;
    // Set wins over the one-to-clear write
    wire logic nxt_done_stat = conv_done | (done_stat_ff & ~(wr_stat & hwdata[`ADCS_STAT_DONE_BIT]));
    wire logic nxt_done_mask = wr_mask ? hwdata[`ADCS_STAT_DONE_BIT] : done_mask_ff;

    wire logic [31:0] rd_ctl0 = {24'h000000, ctl0_ff};
    wire logic [31:0] rd_ctl1 = {28'h0000000, state_ff == adcs_pkg::ST_WARM, state_ff == adcs_pkg::ST_OFF,
                                 ctl0_ff.go, ref_hi_ff};
    wire logic [31:0] rd_data = {21'h000000, result_ff};
    wire logic [31:0] rd_mux =
        (haddr == `ADCS_OFF_CTL0) ? rd_ctl0 :
        (haddr == `ADCS_OFF_CTL1) ? rd_ctl1 :
        (haddr == `ADCS_OFF_DATA) ? rd_data :
        (haddr == `ADCS_OFF_IRQ_STAT) ? {31'h00000000, done_stat_ff} :
        (haddr == `ADCS_OFF_IRQ_MASK) ? {31'h00000000, done_mask_ff} : 32'h00000000;

    // Sequencer: off -> warm -> conv -> idle -> off
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff + `ADCS_CNT_W'(1);
        case (state_ff)
            adcs_pkg::ST_OFF: begin
                nxt_cnt = '0;
                if (start_req) begin
                    nxt_state = adcs_pkg::ST_WARM;
                end
            end
            adcs_pkg::ST_WARM: begin
                if (cnt_ff == warm_last) begin
                    nxt_state = adcs_pkg::ST_CONV;
                    nxt_cnt = '0;
                end
            end
            adcs_pkg::ST_CONV: begin
                if (conv_done) begin
                    nxt_state = adcs_pkg::ST_IDLE;
                    nxt_cnt = '0;
                end
            end
            adcs_pkg::ST_IDLE: begin
                if (start_req) begin
                    nxt_state = adcs_pkg::ST_CONV;
                    nxt_cnt = '0;
                end else if (cnt_ff == idle_last) begin
                    nxt_state = adcs_pkg::ST_OFF;
                    nxt_cnt = '0;
                end
            end
            default: begin
                nxt_state = adcs_pkg::ST_OFF;
                nxt_cnt = '0;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_ff <= adcs_pkg::ST_OFF;
            cnt_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
        end
    end

    // Bus slave: zero wait states, always OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 12'h000;
            hrdata_ff <= 32'h00000000;
        end else begin
            wr_pend_ff <= addr_phase & hwrite;
            wr_addr_ff <= haddr;
            if (rd_req) begin
                hrdata_ff <= rd_mux;
            end
        end
    end

    // Control registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctl0_ff <= `ADCS_RST_CTL0;
            ref_hi_ff <= `ADCS_RST_CTL1;
        end else begin
            if (wr_ctl0 && !ctl0_ff.go) begin
                ctl0_ff.chan <= hwdata[`ADCS_CTL0_CHAN_LSB +: 4];
                ctl0_ff.continuous_select <= hwdata[`ADCS_CTL0_CONTINUOUS_SELECT_BIT];
                ctl0_ff.ref_to_pin <= hwdata[`ADCS_CTL0_REFPIN_BIT];
                ctl0_ff.ref_lo <= hwdata[`ADCS_CTL0_REFLO_BIT];
            end
            if (conv_done) begin
                ctl0_ff.go <= 1'b0;
            end else if (start_req) begin
                ctl0_ff.go <= 1'b1;
            end
            if (wr_ctl1) begin
                ref_hi_ff <= hwdata[`ADCS_CTL1_REFHI_BIT];
            end
        end
    end

    // Result, interrupt and analog-facing outputs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            result_ff <= 11'h000;
            done_stat_ff <= 1'b0;
            done_mask_ff <= `ADCS_RST_MASK;
            irq_ff <= 1'b0;
            mux_ff <= 8'h00;
            pdn_ff <= 1'b1;
            active_ff <= 1'b0;
        end else begin
            if (conv_done) begin
                result_ff <= mod_result;
            end
            done_stat_ff <= nxt_done_stat;
            done_mask_ff <= nxt_done_mask;
            irq_ff <= nxt_done_stat & nxt_done_mask;
            mux_ff <= nxt_chan[3] ? 8'h00 : (8'h01 << nxt_chan[2:0]);
            pdn_ff <= (nxt_state == adcs_pkg::ST_OFF);
            active_ff <= (nxt_state == adcs_pkg::ST_CONV);
        end
    end

    assign hrdata = hrdata_ff;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign mux_sel_onehot = mux_ff;
    assign analog_pdn = pdn_ff;
    assign ref_level_hi_bit = ref_hi_ff;
    assign ref_level_lo_bit = ctl0_ff.ref_lo;
    assign ref_to_pin = ctl0_ff.ref_to_pin;
    assign conv_active = active_ff;
    assign irq = irq_ff;
endmodule

/* File: testbench/adcs_pin_model.sv */
/* Analog pins and modulator: a fixed level per pin.
   Assumes pins already set to their alternate function. */
`timescale 1ns/1ps
module adcs_pin_model (
    input wire logic hclk,
    input wire logic [7:0] mux_sel_onehot,
    input wire logic analog_pdn,
    output logic [10:0] mod_result
);
    logic [10:0] junk_ff = 11'h2aa;
    // Nothing selected gives a changing pattern
    always @(posedge hclk) junk_ff <= ~junk_ff;
    always_comb begin
        mod_result = junk_ff;
        for (int i = 0; i < 8; i++)
            if (mux_sel_onehot[i] && !analog_pdn) mod_result = 11'h0a5 + 11'(i) * 11'h111;
    end
endmodule

/* File: testbench/adcs_seq_properties.sv */
/* Port timing checker for the sequencer, bound to it.
   Assumes one clock, active-low async reset, fixed counts. */
`timescale 1ns/1ps
module adcs_seq_properties (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [7:0] mux_sel_onehot,
    input wire logic analog_pdn,
    input wire logic ref_level_lo_bit,
    input wire logic ref_to_pin,
    input wire logic conv_active,
    input wire logic irq
);
    int ccnt_ff;
    int icnt_ff;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Busy run length and idle run length
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ccnt_ff <= 0;
            icnt_ff <= 0;
        end else begin
            ccnt_ff <= conv_active ? ccnt_ff + 1 : 0;
            icnt_ff <= conv_active ? 0 : icnt_ff + 1;
        end
    end
    property p_wake;
        $rose(conv_active) |-> !analog_pdn;
    endproperty
    a_wake: assert property (p_wake) else $error("conversion began powered down");
    property p_len;
        $fell(conv_active) |-> ccnt_ff == 5129;
    endproperty
    a_len: assert property (p_len) else $error("conversion length wrong");
    property p_warm;
        $fell(analog_pdn) |-> ##40 $rose(conv_active);
    endproperty
    a_warm: assert property (p_warm) else $error("power-up length wrong");
    property p_idle;
        $rose(analog_pdn) |-> icnt_ff == 160;
    endproperty
    a_idle: assert property (p_idle) else $error("powerdown after wrong idle time");
    property p_on;
        conv_active |-> !analog_pdn;
    endproperty
    a_on: assert property (p_on) else $error("powered down while converting");
    property p_mux;
        $onehot0(mux_sel_onehot);
    endproperty
    a_mux: assert property (p_mux) else $error("more than one pin selected");
    property p_hold;
        conv_active && $past(conv_active) |-> $stable({mux_sel_onehot, ref_level_lo_bit, ref_to_pin});
    endproperty
    a_hold: assert property (p_hold) else $error("fields changed mid conversion");
    property p_irq;
        $rose(irq) |-> $past(conv_active, 2);
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt without completion");
    c_conv: cover property ($fell(conv_active));
    c_pdn: cover property ($rose(analog_pdn));
    c_irq: cover property ($rose(irq));
endmodule
bind adcs_seq adcs_seq_properties adcs_seq_properties_inst (.hclk(hclk), .hresetn(hresetn),
    .mux_sel_onehot(mux_sel_onehot), .analog_pdn(analog_pdn), .ref_level_lo_bit(ref_level_lo_bit),
    .ref_to_pin(ref_to_pin), .conv_active(conv_active), .irq(irq));

/* File: testbench/tb_top.sv */
/* Bench: bus tasks, result queue, three conversions.
   Assumes the sequencer and the pin model. */
`timescale 1ns/1ps
module tb_top;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hi = 0;
    logic [11:0] haddr = 12'h000;
    logic [1:0] htrans = 2'h0;
    logic [31:0] hwdata = 32'h0, hrdata, rd, r;
    logic hreadyout, hresp, analog_pdn, hi_b, lo_b, rp_b, conv_active, irq;
    logic [10:0] mod_result;
    logic [7:0] mux_sel_onehot, v;
    int errors = 0, checks = 0, seed = 32'hcb86, cyc = 0, ccnt = 0, clen = 0, t, lat[3];
    logic [10:0] q[$];
    always #2 hclk = ~hclk;
    adcs_seq adcs_seq_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .mod_result(mod_result),
        .mux_sel_onehot(mux_sel_onehot), .analog_pdn(analog_pdn), .ref_level_hi_bit(hi_b),
        .ref_level_lo_bit(lo_b), .ref_to_pin(rp_b), .conv_active(conv_active), .irq(irq));
    adcs_pin_model adcs_pin_model_inst (.hclk(hclk), .mux_sel_onehot(mux_sel_onehot),
        .analog_pdn(analog_pdn), .mod_result(mod_result));
    task conclude;
        $display("errors=%0d checks=%0d", errors, checks);
        if (errors == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task ck(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            errors++;
            $display("ERROR t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task xf(input logic [11:0] a, input logic w, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    // Busy run length and cycle limit
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        ccnt <= (conv_active === 1'b1) ? ccnt + 1 : 0;
        if (conv_active === 1'b0 && ccnt != 0) clen <= ccnt;
        if (cyc == 30000) begin
            errors++;
            conclude;
        end
    end
    initial begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int i = 0; i < 6; i++) begin
            xf(12'(i * 4), 1'b0, 32'h0);
            ck(rd, (i == 1) ? 32'h4 : 32'h0);
        end
        r = $random(seed);
        hi = r[0];
        xf(12'h004, 1'b1, {31'h0, hi});
        @(posedge hclk);
        ck({31'h0, hi_b}, {31'h0, hi});
        // Continuous bit and a code that selects no pin
        xf(12'h000, 1'b1, 32'h18);
        @(posedge hclk);
        ck({24'h0, mux_sel_onehot}, 32'h0);
        xf(12'h000, 1'b0, 32'h0);
        ck(rd, 32'h18);
        ck({31'h0, hresp}, 32'h0);
        for (int i = 0; i < 3; i++) begin
            if (i == 2) begin
                repeat (140) @(posedge hclk);
                ck({31'h0, analog_pdn}, 32'h0);
                repeat (20) @(posedge hclk);
                ck({31'h0, analog_pdn}, 32'h1);
            end
            xf(12'h010, 1'b1, 32'(i < 2));
            r = $random(seed);
            v = {1'b1, r[1:0], 2'b00, r[4:2]};
            q.push_back(11'h0a5 + 11'(v[2:0]) * 11'h111);
            xf(12'h000, 1'b1, {24'h0, v});
            lat[i] = 0;
            while (conv_active !== 1'b1 && lat[i] < 300) begin
                @(posedge hclk);
                lat[i]++;
            end
            ck({24'h0, mux_sel_onehot}, 32'h1 << v[2:0]);
            ck({30'h0, lo_b, rp_b}, {30'h0, v[6:5]});
            xf(12'h000, 1'b1, {24'h0, v ^ 8'h83});
            xf(12'h000, 1'b0, 32'h0);
            ck(rd, {24'h0, v});
            xf(12'h004, 1'b0, 32'h0);
            ck(rd, {30'h0, 1'b1, hi});
            t = 0;
            while (conv_active !== 1'b0 && t < 6000) begin
                @(posedge hclk);
                t++;
            end
            @(posedge hclk);
            ck(32'(clen), 32'd5129);
            xf(12'h000, 1'b0, 32'h0);
            ck(rd, {24'h0, v & 8'h7f});
            xf(12'h008, 1'b0, 32'h0);
            ck(rd, {21'h0, q.pop_front()});
            xf(12'h00c, 1'b0, 32'h0);
            ck(rd, 32'h1);
            ck({31'h0, irq}, 32'(i < 2));
            xf(12'h00c, 1'b1, 32'h1);
            repeat (2) @(posedge hclk);
            ck({31'h0, irq}, 32'h0);
        end
        ck(32'(lat[0] - lat[1]), 32'd40);
        ck(32'(lat[2]), 32'(lat[0]));
        conclude;
    end
endmodule
